//--- rtl/nim_pkg.sv
`default_nettype none
package nim_pkg;
  // ****************************************************************
  // Register map (word index; byte address is index times four)
  // ****************************************************************
  localparam logic [7:0] IDX_MAIN_MASK   = 8'h16;
  localparam logic [7:0] IDX_TF_MASK     = 8'h17;
  localparam logic [7:0] IDX_EW_MASK     = 8'h18;
  localparam logic [7:0] IDX_TGT_MASK    = 8'h19;
  localparam logic [7:0] IDX_MAIN_STATUS = 8'h1A;
  localparam logic [7:0] IDX_TF_STATUS   = 8'h1B;
  localparam logic [7:0] IDX_EW_STATUS   = 8'h1C;
  localparam logic [7:0] IDX_TGT_STATUS  = 8'h1D;
  localparam int         ADDR_LSB        = 2;
  localparam int         ADDR_BITS       = 8;
  // ****************************************************************
  // Reset values and reserved bits
  // ****************************************************************
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] MAIN_VALID      = 8'hFE;
  localparam logic [7:0] TF_VALID        = 8'hFF;
  localparam logic [7:0] EW_VALID        = 8'hFE;
  localparam logic [7:0] TGT_VALID       = 8'hFB;
  // ****************************************************************
  // Main status bit positions
  // ****************************************************************
  localparam int MAIN_OSC        = 7;
  localparam int MAIN_FIFO_LEVEL = 6;
  localparam int MAIN_RX_START   = 5;
  localparam int MAIN_RX_END     = 4;
  localparam int MAIN_TX_END     = 3;
  localparam int MAIN_COLLISION  = 2;
  localparam int MAIN_RX_RESTART = 1;
  // ****************************************************************
  // FIFO water levels
  // ****************************************************************
  localparam int FIFO_CNT_W   = 10;
  localparam int RX_LEVEL_MAX = 300;
  localparam int TX_LEVEL_MIN = 200;
endpackage
`default_nettype wire

//--- rtl/nim_irq.sv
// Functional notes
// - Timer/field mask, one bit per event, a one masks, resets to zero.
// - Error/wake-up mask bits seven to one; bit zero reserved.
// - Target mask bits seven to three and one to zero; bit two reserved.
// - Oscillator-stable flag sets once enabled oscillator has settled.
// - FIFO level flag rises during receive above 300 bytes.
// - FIFO level flag rises during transmit below 200 bytes.
// - Main status bits five to two: rx start, rx end, tx end, collision.
// - Reception restart flag sets when a frame is dropped as disturbance.
// - Timer/field status bits seven to five: command done, timers expired.
// - Bit four on field rising above level, bit three on dropping below.
// - Guard-time flag, bit one, after field switched on without collision.
// - Bit zero sets when target mode recognises the initiator bit rate.
// - Reading timer/field status returns flags then clears them all.
// - Reading main status returns flags then clears them all.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module nim_irq (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic [nim_pkg::ADDR_BITS-1:0]  wb_adr_i,
  input  wire logic [31:0]                    wb_dat_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic                           wb_we_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  output logic                                wb_err_o,
  input  wire logic                           osc_enable_i,
  input  wire logic                           osc_stable_i,
  input  wire logic                           rx_active_i,
  input  wire logic                           tx_active_i,
  input  wire logic [nim_pkg::FIFO_CNT_W-1:0] fifo_count_i,
  input  wire logic [7:1]                     main_event_i,
  input  wire logic [7:0]                     timer_field_event_i,
  input  wire logic [7:0]                     error_wakeup_event_i,
  input  wire logic [7:0]                     target_event_i,
  output logic                                irq_o
);
  import nim_pkg::*;

  if (FIFO_CNT_W < $clog2(RX_LEVEL_MAX + 1)) begin : g_cnt_check
    $error("FIFO count too narrow for water levels");
  end

  // ****************************************************************
  // Event qualification
  // ****************************************************************
  logic       osc_seen;
  logic       next_osc_seen;
  logic       osc_rise;
  logic       level_hit;
  logic       level_prev;
  logic       next_level_prev;
  logic [7:0] main_ev;
  logic [7:0] tf_ev;
  logic [7:0] ew_ev;
  logic [7:0] tgt_ev;

  always_comb begin
    osc_rise      = osc_enable_i && osc_stable_i && !osc_seen;
    next_osc_seen = osc_enable_i && osc_stable_i;
    level_hit     = (rx_active_i &&
                     fifo_count_i > FIFO_CNT_W'(RX_LEVEL_MAX)) ||
                    (tx_active_i &&
                     fifo_count_i < FIFO_CNT_W'(TX_LEVEL_MIN));
    next_level_prev = level_hit;
    main_ev = {main_event_i, 1'b0} & MAIN_VALID;
    main_ev[MAIN_OSC]        = osc_rise;
    main_ev[MAIN_FIFO_LEVEL] = level_hit && !level_prev;
    // Restart flag comes from the discard pulse on bit one
    main_ev[MAIN_RX_RESTART] = main_event_i[MAIN_RX_RESTART];
    tf_ev  = timer_field_event_i & TF_VALID;
    ew_ev  = error_wakeup_event_i & EW_VALID;
    tgt_ev = target_event_i & TGT_VALID;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_seen   <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      osc_seen   <= next_osc_seen;
      level_prev <= next_level_prev;
    end
  end

  // ****************************************************************
  // Wishbone slave and registers
  // ****************************************************************
  logic [7:0]  main_mask;
  logic [7:0]  tf_mask;
  logic [7:0]  ew_mask;
  logic [7:0]  tgt_mask;
  logic [7:0]  main_st;
  logic [7:0]  tf_st;
  logic [7:0]  ew_st;
  logic [7:0]  tgt_st;
  logic [7:0]  next_main_mask;
  logic [7:0]  next_tf_mask;
  logic [7:0]  next_ew_mask;
  logic [7:0]  next_tgt_mask;
  logic [7:0]  next_main_st;
  logic [7:0]  next_tf_st;
  logic [7:0]  next_ew_st;
  logic [7:0]  next_tgt_st;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        next_err;
  logic        next_irq;
  logic        req;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic        hit;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    merge_byte = en ? new_v : old_v;
  endfunction

  function automatic logic reg_is(input logic [7:0] cur_idx,
                                  input logic [7:0] want_idx);
    reg_is = (cur_idx == want_idx);
  endfunction

  function automatic logic any_pending(input logic [7:0] st_v,
                                       input logic [7:0] mask_v);
    any_pending = |(st_v & ~mask_v);
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  always_comb begin
    req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    idx      = {{ADDR_LSB{1'b0}}, wb_adr_i[ADDR_BITS-1:ADDR_LSB]};
    hit      = (idx >= IDX_MAIN_MASK) && (idx <= IDX_TGT_STATUS);
    wr       = req && wb_we_i && hit;
    rd       = req && !wb_we_i && hit;
    next_ack = req && hit;
    next_err = req && !hit;
  end

  // ****************************************************************
  // Read data, zero outside the ack cycle of a read
  // ****************************************************************
  always_comb begin
    next_dat = 32'h0000_0000;
    if (rd) begin
      unique case (idx)
        IDX_MAIN_MASK:   next_dat[7:0] = main_mask;
        IDX_TF_MASK:     next_dat[7:0] = tf_mask;
        IDX_EW_MASK:     next_dat[7:0] = ew_mask;
        IDX_TGT_MASK:    next_dat[7:0] = tgt_mask;
        IDX_MAIN_STATUS: next_dat[7:0] = main_st;
        IDX_TF_STATUS:   next_dat[7:0] = tf_st;
        IDX_EW_STATUS:   next_dat[7:0] = ew_st;
        IDX_TGT_STATUS:  next_dat[7:0] = tgt_st;
        default:         next_dat[7:0] = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Mask registers
  // ****************************************************************
  always_comb begin
    next_main_mask = merge_byte(main_mask, wb_dat_i[7:0] & MAIN_VALID,
                                wr && wb_sel_i[0] && reg_is(idx, IDX_MAIN_MASK));
    next_tf_mask   = merge_byte(tf_mask, wb_dat_i[7:0] & TF_VALID,
                                wr && wb_sel_i[0] && reg_is(idx, IDX_TF_MASK));
    next_ew_mask   = merge_byte(ew_mask, wb_dat_i[7:0] & EW_VALID,
                                wr && wb_sel_i[0] && reg_is(idx, IDX_EW_MASK));
    next_tgt_mask  = merge_byte(tgt_mask, wb_dat_i[7:0] & TGT_VALID,
                                wr && wb_sel_i[0] && reg_is(idx, IDX_TGT_MASK));
  end

  // ****************************************************************
  // Status registers, cleared by reading
  // ****************************************************************
  always_comb begin
    // A fresh event in the clearing cycle survives
    next_main_st = ((rd && reg_is(idx, IDX_MAIN_STATUS)) ? 8'h00 : main_st)
                   | main_ev;
    next_tf_st   = ((rd && reg_is(idx, IDX_TF_STATUS)) ? 8'h00 : tf_st)
                   | tf_ev;
    next_ew_st   = ((rd && reg_is(idx, IDX_EW_STATUS)) ? 8'h00 : ew_st)
                   | ew_ev;
    next_tgt_st  = ((rd && reg_is(idx, IDX_TGT_STATUS)) ? 8'h00 : tgt_st)
                   | tgt_ev;
  end

  // ****************************************************************
  // Interrupt request
  // ****************************************************************
  always_comb begin
    next_irq = any_pending(next_main_st, next_main_mask) ||
               any_pending(next_tf_st, next_tf_mask) ||
               any_pending(next_ew_st, next_ew_mask) ||
               any_pending(next_tgt_st, next_tgt_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_mask <= MASK_RESET;
      tf_mask   <= MASK_RESET;
      ew_mask   <= MASK_RESET;
      tgt_mask  <= MASK_RESET;
      main_st   <= 8'h00;
      tf_st     <= 8'h00;
      ew_st     <= 8'h00;
      tgt_st    <= 8'h00;
      wb_dat_o  <= 32'h0000_0000;
      wb_ack_o  <= 1'b0;
      wb_err_o  <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      main_mask <= next_main_mask;
      tf_mask   <= next_tf_mask;
      ew_mask   <= next_ew_mask;
      tgt_mask  <= next_tgt_mask;
      main_st   <= next_main_st;
      tf_st     <= next_tf_st;
      ew_st     <= next_ew_st;
      tgt_st    <= next_tgt_st;
      wb_dat_o  <= next_dat;
      wb_ack_o  <= next_ack;
      wb_err_o  <= next_err;
      irq_o     <= next_irq;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |((main_st & ~main_mask) | (tf_st & ~tf_mask) |
               (ew_st & ~ew_mask) | (tgt_st & ~tgt_mask)))
    else $error("irq does not follow unmasked flags");
  mask_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
    main_mask == MAIN_VALID && tf_mask == TF_VALID &&
    ew_mask == EW_VALID && tgt_mask == TGT_VALID |-> !irq_o)
    else $error("irq raised with every event masked");

  // ****************************************************************
  // Assertions: clearing reads
  // ****************************************************************
  tf_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_TF_STATUS |=> tf_st == $past(tf_ev))
    else $error("timer status not cleared by read");
  main_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_MAIN_STATUS |=> main_st == $past(main_ev))
    else $error("main status not cleared by read");
  event_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_TF_STATUS && tf_ev[0] |=> tf_st[0])
    else $error("event lost on clearing read");
  main_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_MAIN_STATUS && main_ev != 8'h00
    |=> (main_st & $past(main_ev)) == $past(main_ev))
    else $error("main event lost on clearing read");
  read_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_TF_STATUS |=> wb_ack_o && wb_dat_o[7:0] == $past(tf_st))
    else $error("timer status read data wrong");
  main_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_MAIN_STATUS |=> wb_ack_o && wb_dat_o[7:0] == $past(main_st))
    else $error("main status read data wrong");

  // ****************************************************************
  // Assertions: mask registers
  // ****************************************************************
  mask_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> tf_mask == MASK_RESET && ew_mask == MASK_RESET &&
                     tgt_mask == MASK_RESET)
    else $error("mask not zero after reset");
  tf_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_sel_i[0] && idx == IDX_TF_MASK |=> tf_mask == $past(wb_dat_i[7:0]))
    else $error("timer mask write lost");
  ew_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_sel_i[0] && idx == IDX_EW_MASK
    |=> ew_mask == ($past(wb_dat_i[7:0]) & EW_VALID))
    else $error("error mask write lost");
  tgt_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_sel_i[0] && idx == IDX_TGT_MASK
    |=> tgt_mask == ($past(wb_dat_i[7:0]) & TGT_VALID))
    else $error("target mask write lost");
  ew_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ew_mask[0] == 1'b0 && main_st[0] == 1'b0)
    else $error("reserved bit set");
  tgt_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tgt_mask[2] == 1'b0)
    else $error("target reserved mask bit set");

  // ****************************************************************
  // Assertions: event flags
  // ****************************************************************
  osc_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_enable_i && osc_stable_i && !osc_seen |=> main_st[MAIN_OSC])
    else $error("oscillator flag missing");
  fifo_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_active_i && !tx_active_i && fifo_count_i == 10'd301 && !level_prev
    |=> main_st[MAIN_FIFO_LEVEL])
    else $error("rx water level flag missing");
  fifo_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_active_i && !rx_active_i && fifo_count_i == 10'd200 |-> !level_hit)
    else $error("tx water level at 200 fired");
  tx_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_active_i && !rx_active_i && fifo_count_i == FIFO_CNT_W'(TX_LEVEL_MIN - 1) &&
    !level_prev |=> main_st[MAIN_FIFO_LEVEL])
    else $error("tx water level flag missing");
  main_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    main_event_i[5:2] != 4'h0
    |=> (main_st[5:2] & $past(main_event_i[5:2])) == $past(main_event_i[5:2]))
    else $error("frame event flag missing");
  restart_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    main_event_i[MAIN_RX_RESTART] |=> main_st[MAIN_RX_RESTART])
    else $error("restart flag missing");
  tf_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_field_event_i[7:5] != 3'h0
    |=> (tf_st[7:5] & $past(timer_field_event_i[7:5])) == $past(timer_field_event_i[7:5]))
    else $error("timer flag missing");
  field_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_field_event_i[4:3] != 2'h0
    |=> (tf_st[4:3] & $past(timer_field_event_i[4:3])) == $past(timer_field_event_i[4:3]))
    else $error("field flag missing");
  guard_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_field_event_i[1] |=> tf_st[1])
    else $error("guard time flag missing");
  rate_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_field_event_i[0] |=> tf_st[0])
    else $error("bit rate flag missing");

  // ****************************************************************
  // Assertions: bus protocol
  // ****************************************************************
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  err_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !hit |=> wb_err_o && !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  quiet_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");
  irq_cv: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  clr_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_TF_STATUS && tf_st != 8'h00);
  race_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_MAIN_STATUS && main_ev != 8'h00);
  err_cv: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);
  fifo_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    main_ev[MAIN_FIFO_LEVEL]);
endmodule
`default_nettype wire

//--- tb/nim_host.sv
`timescale 1ns/1ns
`default_nettype none
module nim_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  idx_i,
  input  wire logic [7:0]  dat_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o,
  output logic [31:0]      rd_o,
  output logic             er_o,
  output logic             done_o
);
  // ****
  // Single classic cycle, held until ack or err
  // ****
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      cyc_o <= 1'b0;
    end else if (!cyc_o && go_i) begin
      cyc_o <= 1'b1;
      we_o <= we_i;
      adr_o <= {idx_i[5:0], 2'b00};
      dat_o <= {24'h000000, dat_i};
    end else if (cyc_o && (ack_i || err_i)) begin
      cyc_o <= 1'b0;
      rd_o <= rdat_i;
      er_o <= err_i;
      done_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/test_nim_irq.sv
`timescale 1ns/1ns
`default_nettype none
module test_nim_irq;
  import nim_pkg::*;
  logic        clk_i = 0, rst_i = 1, go = 0, hwe = 0, run = 0;
  logic        osc_en = 0, osc_st = 0, rx = 0, tx = 0;
  logic [7:0]  hidx = 0, hdat = 0, te = 0, ee = 0, ge = 0, r;
  logic [7:1]  me = 0;
  logic [9:0]  fc = 0;
  logic [31:0] wdat, rdat, rd;
  logic [7:0]  adr, st[4], mk[4], ev[4], expq[$];
  logic [7:0]  vld[4] = '{MAIN_VALID, TF_VALID, EW_VALID, TGT_VALID};
  logic [2:0]  k;
  logic        cyc, wwe, ack, err, irq, done, er, fcn, ocn, pfc, posc, tk, eirq, hung = 0;
  int          mismatches = 0, comparisons = 0;
  integer      seed = 32'h2f7f;
  nim_irq nim_irq_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'h1), .wb_we_i(wwe), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .osc_enable_i(osc_en), .osc_stable_i(osc_st),
    .rx_active_i(rx), .tx_active_i(tx), .fifo_count_i(fc), .main_event_i(me),
    .timer_field_event_i(te), .error_wakeup_event_i(ee), .target_event_i(ge), .irq_o(irq));
  nim_host nim_host_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(hwe), .idx_i(hidx),
    .dat_i(hdat), .ack_i(ack), .err_i(err), .rdat_i(rdat), .cyc_o(cyc), .we_o(wwe),
    .adr_o(adr), .dat_o(wdat), .rd_o(rd), .er_o(er), .done_o(done));
  initial forever #4 clk_i = ~clk_i;
  // ****
  // Reference model
  // ****
  always @(posedge clk_i) begin
    fcn = (rx && fc > 300) || (tx && fc < 200);
    ocn = osc_en && osc_st;
    ev[0] = {ocn && !posc, fcn && !pfc, me[5:1], 1'b0};
    ev[1] = te;
    ev[2] = ee & EW_VALID;
    ev[3] = ge & TGT_VALID;
    k = 3'(adr[7:2] - 6'h16);
    tk = cyc && !ack && !err && adr[7:2] >= 6'h16 && adr[7:2] <= 6'h1D;
    if (rst_i) begin
      st = '{default: 8'h00};
      mk = '{default: 8'h00};
      pfc = 0;
      posc = 0;
    end else begin
      pfc = fcn;
      posc = ocn;
      if (tk && !wwe) expq.push_back(k[2] ? st[k[1:0]] : mk[k[1:0]]);
      if (tk && !wwe && k[2]) st[k[1:0]] = 8'h00;
      if (tk && wwe && !k[2]) mk[k[1:0]] = wdat[7:0] & vld[k[1:0]];
      for (int i = 0; i < 4; i++) st[i] |= ev[i];
    end
    eirq = 0;
    for (int i = 0; i < 4; i++) eirq |= |(st[i] & ~mk[i]);
  end
  always @(posedge clk_i) begin
    me <= run ? 7'($random(seed) & $random(seed) & $random(seed)) : 7'h00;
    te <= run ? 8'($random(seed) & $random(seed) & $random(seed)) : 8'h00;
    ee <= run ? 8'($random(seed) & $random(seed) & $random(seed)) : 8'h00;
    ge <= run ? 8'($random(seed) & $random(seed) & $random(seed)) : 8'h00;
    osc_en <= run && 1'($random(seed));
    osc_st <= run && 1'($random(seed));
    rx <= run && 1'($random(seed));
    tx <= run && 1'($random(seed));
    fc <= 10'($random(seed));
  end
  always @(negedge clk_i) if (!rst_i) chk_irq(irq, eirq);
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_irq(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task chk_err(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: err %b expected %b", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    if (!hung) begin
      @(posedge clk_i);
      go <= 1;
      hwe <= w;
      hidx <= i;
      hdat <= d;
      @(posedge clk_i);
      go <= 0;
      n = 0;
      while (!done && n < 20) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      if (!done) begin
        mismatches++;
        hung = 1;
        $display("mismatch at %0t: no answer on the bus", $time);
      end else if (i < 8'h16 || i > 8'h1D) begin
        chk_err(er, 1'b1);
      end else begin
        chk_err(er, 1'b0);
        if (!w) chk_reg(rd, {24'h000000, expq.pop_front()});
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 8'h16; i <= 8'h1D; i++) bus(0, 8'(i), 8'h00);
    for (int i = 0; i < 4; i++) bus(1, 8'(8'h16 + i), 8'hFF);
    for (int i = 0; i < 4; i++) bus(0, 8'(8'h16 + i), 8'h00);
    bus(0, 8'h1B, 8'h00);
    run <= 1;
    repeat (400) begin
      r = 8'($random(seed));
      bus(r[0] & r[4], r[1] ? 8'h1A + r[3:2] : (r[5:4] == 0 ? 8'h20 : 8'h16 + r[7:6]),
          8'($random(seed)));
    end
    finish_test;
  end
endmodule
`default_nettype wire
